/* imrs_pkg.sv */
// Purpose: shared constants and types of the two-wire master read sequencer
// Assumes: eight-bit data bytes, open-drain bus pins
// Notes: bit engine timing is counted in link clock cycles

package imrs_pkg;

  // ---------------------------------------------------------------
  // byte framing
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int RW_POS = 0;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam int PREFIX_LSB = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // link clock cycles per quarter of a serial clock period
  localparam int QUARTER_CYC = 16;
  localparam int SYNC_STAGES = 2;
  localparam int LINK_SYNC_W = 5;
  localparam int SYS_SYNC_W = 2;

  // commands passed from the sequencer to the bit engine
  typedef enum logic [1:0] {CMD_START, CMD_TX, CMD_RX, CMD_STOP} imrs_cmd_t;

endpackage

/* imrs_sync.sv */
// Purpose: two-stage synchroniser for independent single-bit levels
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps

module imrs_sync
  import imrs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // destination clock
  input wire logic clk,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } imrs_sync_t;

  imrs_sync_t r;
  imrs_sync_t next_r;

  // no reset here: the chain must pass the reset level itself
  always_comb
  begin
    next_r.meta = d;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  assign q = r.stable;

endmodule

/* imrs_bit_engine.sv */
// Purpose: bus-level engine for START, byte shift, acknowledge and STOP
// Assumes: all inputs except the command payload already synchronised to linkClk
// Notes: holds the serial clock low between commands, except after STOP, so the bus is
//   stretched rather than corrupted while software is slow
`timescale 1ns/10ps

module imrs_bit_engine
  import imrs_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
)
(
  // link clock domain
  input wire logic linkClk,
  input wire logic linkRst_n,
  input wire logic linkEn,
  // command handshake, payload stable while a toggle is pending
  input wire logic reqSync,
  input wire imrs_cmd_t cmd,
  input wire logic [DATA_W-1:0] cmdData,
  input wire logic cmdNak,
  output logic doneT,
  output logic firstT,
  output logic ackBit,
  output logic [DATA_W-1:0] rxByte,
  // synchronised bus levels and pin drives
  input wire logic sdaSync,
  input wire logic sclSync,
  output logic sdaOe,
  output logic sclOe
);

  localparam int CNT_W = (QUARTER > 1) ? $clog2(QUARTER) : 1;

  typedef enum {E_IDLE, E_START, E_BIT, E_STOP} imrs_est_t;

  typedef struct packed {
    imrs_est_t st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitIdx;
    logic [DATA_W-1:0] sh;
    logic sclLow;
    logic sdaLow;
    logic reqSeen;
    logic doneT;
    logic firstT;
    logic ack;
    logic isRx;
    logic nak;
  } imrs_eng_t;

  imrs_eng_t r;
  imrs_eng_t next_r;

  // ---------------------------------------------------------------
  // phase sequencer: each bus step is four quarter periods
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [3:0] nextIdx;
    logic [DATA_W-1:0] shifted;
    nextIdx = r.bitIdx + 4'h1;
    shifted = r.isRx ? r.sh : {r.sh[DATA_W-2:0], 1'b0};
    next_r = r;
    if (!linkEn)
      next_r = r;
    else if (r.st == E_IDLE)
    begin
      if (reqSync != r.reqSeen)
      begin
        next_r.reqSeen = reqSync;
        next_r.cnt = '0;
        next_r.ph = 2'h0;
        next_r.bitIdx = 4'h0;
        next_r.sh = cmdData;
        next_r.isRx = (cmd == CMD_RX);
        next_r.nak = cmdNak;
        case (cmd)
          CMD_START:
          begin
            next_r.st = E_START;
            next_r.sdaLow = 1'b0;
          end
          CMD_STOP:
          begin
            next_r.st = E_STOP;
            next_r.sdaLow = 1'b1;
          end
          default:
          begin
            next_r.st = E_BIT;
            next_r.sdaLow = (cmd == CMD_TX) & ~cmdData[DATA_W-1];
          end
        endcase
      end
    end
    // a slave holding the clock low stretches the first high quarter
    else if (r.ph == 2'h1 && !sclSync)
      next_r.cnt = '0;
    else if (r.cnt != CNT_W'(QUARTER - 1))
      next_r.cnt = r.cnt + 1'b1;
    else
    begin
      next_r.cnt = '0;
      next_r.ph = r.ph + 2'h1;
      case (r.ph)
        2'h0: next_r.sclLow = 1'b0;
        2'h1:
        begin
          if (r.st == E_START)
            next_r.sdaLow = 1'b1;
          if (r.st == E_STOP)
            next_r.sdaLow = 1'b0;
          if (r.st == E_BIT && r.isRx && r.bitIdx != ACK_SLOT)
            next_r.sh = {r.sh[DATA_W-2:0], sdaSync};
          if (r.st == E_BIT && !r.isRx && r.bitIdx == ACK_SLOT)
            next_r.ack = sdaSync;
        end
        2'h2: next_r.sclLow = (r.st != E_STOP);
        default:
        begin
          if (r.st != E_BIT || r.bitIdx == ACK_SLOT)
          begin
            next_r.st = E_IDLE;
            next_r.doneT = ~r.doneT;
            next_r.sdaLow = 1'b0;
          end
          else
          begin
            next_r.bitIdx = nextIdx;
            next_r.sh = shifted;
            // first address bit is out: data register may be refilled
            if (r.bitIdx == 4'h0 && !r.isRx)
              next_r.firstT = ~r.firstT; // RULE11
            next_r.sdaLow = (nextIdx == ACK_SLOT) ?
              (r.isRx & ~r.nak) : (~r.isRx & ~shifted[DATA_W-1]); // RULE8
          end
        end
      endcase
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign doneT = r.doneT;
  assign firstT = r.firstT;
  assign ackBit = r.ack;
  assign rxByte = r.sh;
  assign sdaOe = r.sdaLow;
  assign sclOe = r.sclLow;

endmodule

/* imrs_top.sv */
// Purpose: master read sequencer of a two-wire serial controller
// Assumes: software ports are on sys_clk; bus pins are open drain
// Notes: bus timing runs on linkClk; commands cross by toggle handshake
//
// Summary of operation
// RULE1 - software loads address with read bit first
// RULE2 - single byte read needs not-acknowledge early
// RULE3 - START, send address byte, sample acknowledge
// RULE4 - address refused: flag, acknowledge valid, no acknowledge
// RULE5 - stop after refusal flushes data, sends STOP
// RULE6 - acknowledged read address: receive byte, interrupt
// RULE7 - software reads data, requests final not-acknowledge
// RULE8 - acknowledge each byte unless not-acknowledge requested
// RULE9 - final byte raises flag, stop sends STOP
// RULE10 - ten bit header starts 11110 plus two bits
// RULE11 - transmit interrupt after first address bit out
// RULE12 - software writes low address byte then
// RULE13 - software requests repeated START, writes read header
// RULE14 - acknowledged second byte: repeated START, third byte
// RULE15 - single ten bit read: not-acknowledge with header
// RULE16 - slave width mode never limits master addresses
// RULE17 - software enables interface in master mode first
// RULE18 - transmit interrupt means data register empty
`timescale 1ns/10ps

module imrs_top
  import imrs_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
)
(
  // system clock domain
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // link clock for the bus engine
  input wire logic linkClk,
  // configuration levels
  input wire logic interfaceEnable,
  input wire logic modeMaster,
  input wire logic txIntEnable,
  input wire logic notAckRequest,
  // control strobes
  input wire logic startSet,
  input wire logic stopSet,
  // data register access
  input wire logic dataWrite,
  input wire logic [DATA_W-1:0] dataWrData,
  input wire logic dataRead,
  output logic [DATA_W-1:0] dataRdData,
  // status
  output logic startPending,
  output logic stopPending,
  output logic txDataEmpty,
  output logic rxDataFull,
  output logic notAckIntFlag,
  output logic ackValidFlag,
  output logic ackFlag,
  output logic tenBitHeader,
  output logic busy,
  output logic txInterrupt,
  output logic rxInterrupt,
  // open-drain bus pins
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe
);

  typedef enum {S_IDLE, S_START, S_TX, S_HOLD, S_RX, S_RXWAIT, S_HALT,
    S_STOP} imrs_st_t;

  typedef struct packed {
    imrs_st_t st;
    logic startBit;
    logic stopBit;
    logic [DATA_W-1:0] dataReg;
    logic dataFull;
    logic txWait;
    logic [DATA_W-1:0] rxData;
    logic rxFull;
    logic nck;
    logic ackValid;
    logic ack;
    logic readMode;
    logic tenBit;
    logic reqT;
    imrs_cmd_t cmd;
    logic [DATA_W-1:0] cmdData;
    logic cmdNak;
    logic doneSeen;
    logic firstSeen;
  } imrs_seq_t;

  imrs_seq_t r;
  imrs_seq_t next_r;

  logic [LINK_SYNC_W-1:0] linkSync;
  logic [SYS_SYNC_W-1:0] sysSync;
  logic engDoneT;
  logic engFirstT;
  logic engAck;
  logic [DATA_W-1:0] engRx;
  logic doneEv;
  logic firstEv;

  // ---------------------------------------------------------------
  // clock domain crossings
  // ---------------------------------------------------------------
  // reset, enable, request toggle and bus pins into the link domain
  imrs_sync #(.WIDTH(LINK_SYNC_W)) linkSyncInst (
    .clk(linkClk),
    .d({reset_n, clkEn, r.reqT, sdaIn, sclIn}),
    .q(linkSync)
  );

  // completion and first-bit toggles back into the system domain
  imrs_sync #(.WIDTH(SYS_SYNC_W)) sysSyncInst (
    .clk(sys_clk),
    .d({engDoneT, engFirstT}),
    .q(sysSync)
  );

  imrs_bit_engine #(.QUARTER(QUARTER)) engine (
    .linkClk(linkClk),
    .linkRst_n(linkSync[4]),
    .linkEn(linkSync[3]),
    .reqSync(linkSync[2]),
    .cmd(r.cmd),
    .cmdData(r.cmdData),
    .cmdNak(r.cmdNak),
    .doneT(engDoneT),
    .firstT(engFirstT),
    .ackBit(engAck),
    .rxByte(engRx),
    .sdaSync(linkSync[1]),
    .sclSync(linkSync[0]),
    .sdaOe(sdaOe),
    .sclOe(sclOe)
  );

  assign doneEv = sysSync[1] != r.doneSeen;
  assign firstEv = sysSync[0] != r.firstSeen;

  // ---------------------------------------------------------------
  // transaction sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.doneSeen = sysSync[1];
    next_r.firstSeen = sysSync[0];
    // software read goes first so a byte landing now is not lost
    if (dataRead)
      next_r.rxFull = 1'b0;
    // shift register took the byte once its first bit left
    if (firstEv && r.txWait)
    begin
      next_r.dataFull = 1'b0; // RULE11 RULE18
      next_r.txWait = 1'b0;
    end
    case (r.st)
      S_IDLE:
      begin
        // any address width may go out; slave width mode is not read
        if (r.startBit && interfaceEnable && modeMaster) // RULE16
        begin
          next_r.startBit = 1'b0;
          next_r.ackValid = 1'b0;
          next_r.cmd = CMD_START; // RULE3
          next_r.reqT = ~r.reqT;
          next_r.st = S_START;
        end
        else if (r.stopBit)
          next_r.stopBit = 1'b0;
      end
      S_START:
      begin
        // waits here, bus held, until software has loaded a byte
        if ((doneEv || r.doneSeen == r.reqT) && r.dataFull)
        begin
          next_r.cmd = CMD_TX; // RULE3 RULE14
          next_r.cmdData = r.dataReg;
          next_r.readMode = r.dataReg[RW_POS];
          next_r.tenBit = r.dataReg[DATA_W-1:PREFIX_LSB] ==
            TEN_BIT_PREFIX; // RULE10
          next_r.txWait = 1'b1;
          next_r.reqT = ~r.reqT;
          next_r.st = S_TX;
        end
      end
      S_TX:
      begin
        if (doneEv)
        begin
          next_r.ackValid = 1'b1;
          next_r.ack = ~engAck;
          if (engAck)
          begin
            next_r.nck = 1'b1; // RULE4
            next_r.st = S_HALT;
          end
          else if (r.readMode)
          begin
            next_r.cmd = CMD_RX; // RULE6
            next_r.cmdNak = notAckRequest; // RULE8
            next_r.reqT = ~r.reqT;
            next_r.st = S_RX;
          end
          else
            next_r.st = S_HOLD;
        end
      end
      S_HOLD:
      begin
        // write-direction header sent: restart, stop or next byte
        if (r.startBit)
        begin
          next_r.startBit = 1'b0;
          next_r.cmd = CMD_START; // RULE14
          next_r.reqT = ~r.reqT;
          next_r.st = S_START;
        end
        else if (r.stopBit)
        begin
          next_r.cmd = CMD_STOP;
          next_r.reqT = ~r.reqT;
          next_r.st = S_STOP;
        end
        else if (r.dataFull && !r.txWait)
        begin
          next_r.cmd = CMD_TX;
          next_r.cmdData = r.dataReg;
          next_r.readMode = r.dataReg[RW_POS];
          next_r.txWait = 1'b1;
          next_r.reqT = ~r.reqT;
          next_r.st = S_TX;
        end
      end
      S_RX:
      begin
        if (doneEv)
        begin
          next_r.rxData = engRx;
          next_r.rxFull = 1'b1; // RULE6
          if (r.cmdNak)
          begin
            next_r.nck = 1'b1; // RULE9
            next_r.st = S_HALT;
          end
          else
            next_r.st = S_RXWAIT;
        end
      end
      S_RXWAIT:
      begin
        // bus is stretched until software has taken the byte
        if (r.stopBit)
        begin
          next_r.cmd = CMD_STOP;
          next_r.reqT = ~r.reqT;
          next_r.st = S_STOP;
        end
        else if (!r.rxFull)
        begin
          next_r.cmd = CMD_RX;
          next_r.cmdNak = notAckRequest; // RULE8
          next_r.reqT = ~r.reqT;
          next_r.st = S_RX;
        end
      end
      S_HALT:
      begin
        // refused transfer: pending transmit data is dropped
        if (r.stopBit || r.startBit)
        begin
          next_r.dataFull = 1'b0; // RULE5
          next_r.txWait = 1'b0;
          next_r.reqT = ~r.reqT;
          if (r.stopBit)
          begin
            next_r.cmd = CMD_STOP; // RULE5 RULE9
            next_r.st = S_STOP;
          end
          else
          begin
            next_r.startBit = 1'b0;
            next_r.nck = 1'b0;
            next_r.cmd = CMD_START;
            next_r.st = S_START;
          end
        end
      end
      S_STOP:
      begin
        if (doneEv)
        begin
          next_r.stopBit = 1'b0; // RULE5
          next_r.nck = 1'b0;
          next_r.st = S_IDLE;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
    // software sets come last so they win over hardware clears
    if (startSet)
      next_r.startBit = 1'b1;
    if (stopSet)
      next_r.stopBit = 1'b1;
    if (dataWrite)
    begin
      next_r.dataReg = dataWrData;
      next_r.dataFull = 1'b1;
    end
    if (!clkEn)
      next_r = r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dataRdData = r.rxData;
  assign startPending = r.startBit;
  assign stopPending = r.stopBit;
  assign txDataEmpty = ~r.dataFull; // RULE18
  assign rxDataFull = r.rxFull;
  assign notAckIntFlag = r.nck;
  assign ackValidFlag = r.ackValid;
  assign ackFlag = r.ack;
  assign tenBitHeader = r.tenBit;
  assign busy = (r.st != S_IDLE);
  assign txInterrupt = txIntEnable & interfaceEnable & ~r.dataFull;
  assign rxInterrupt = r.rxFull;
  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_start_issue: assert property (r.st == S_IDLE && r.startBit && // RULE3
    interfaceEnable && modeMaster && clkEn |=> r.st == S_START &&
    r.cmd == CMD_START && $changed(r.reqT))
    else $error("start request not turned into START command");

  a_addr_refused: assert property (r.st == S_TX && doneEv && // RULE4
    engAck && clkEn |=> notAckIntFlag && ackValidFlag && !ackFlag &&
    r.st == S_HALT)
    else $error("address refusal not flagged");

  a_halt_flush: assert property (r.st == S_HALT && r.stopBit && // RULE5
    clkEn |=> r.st == S_STOP && r.cmd == CMD_STOP && !r.txWait)
    else $error("stop after refusal did not flush and stop");

  a_stop_clears: assert property (r.st == S_STOP && doneEv && // RULE5
    clkEn |=> r.st == S_IDLE && !notAckIntFlag)
    else $error("STOP completion did not clear flags");

  a_rx_capture: assert property (r.st == S_RX && doneEv && // RULE6
    clkEn |=> rxDataFull && dataRdData == $past(engRx))
    else $error("received byte not captured");

  a_nak_sample: assert property ($changed(r.reqT) && // RULE8
    r.cmd == CMD_RX |-> r.cmdNak == $past(notAckRequest))
    else $error("acknowledge choice not from request bit");

  a_last_byte: assert property (r.st == S_RX && doneEv && // RULE9
    r.cmdNak && clkEn |=> notAckIntFlag && r.st == S_HALT)
    else $error("final byte did not raise not-acknowledge flag");

  a_tx_empty: assert property (r.txWait && firstEv && // RULE11
    clkEn |=> txDataEmpty || $past(dataWrite))
    else $error("data register not emptied after first bit");

  a_restart: assert property (r.st == S_HOLD && r.startBit && // RULE14
    clkEn |=> r.st == S_START && r.cmd == CMD_START)
    else $error("repeated START not issued");

  c_refused: cover property (r.st == S_TX ##1 r.st == S_HALT
    ##[1:1000] r.st == S_STOP);
  c_rx_loop: cover property (r.st == S_RXWAIT ##[1:1000] r.st == S_RX);
  c_restart: cover property (r.st == S_HOLD ##1 r.st == S_START
    ##[1:1000] r.st == S_TX ##[1:1000] r.st == S_RX);

endmodule

/* imrs_slave_model.sv */
// Purpose: behavioural remote slave for the master read sequencer bench
// Assumes: open-drain bus with pull-ups; master makes every clock edge
// Notes: acknowledges address bytes unless refuse is high; logs traffic
`timescale 1ns/10ps

module imrs_slave_model
(
  // bus levels and pull-down drive
  input wire logic scl,
  input wire logic sda,
  output logic sdaLow,
  // behaviour controls
  input wire logic refuse,
  input wire logic [7:0] txBase,
  // observation for the bench
  output logic [31:0] addrLog,
  output logic [7:0] ackLog,
  output logic [7:0] stopCnt
);
  int bitCnt;
  logic [7:0] shift;
  logic [7:0] nSent;
  logic [7:0] cur;
  logic active, reading, firstByte, sending;

  initial
  begin
    {sdaLow, active, reading, firstByte, sending} = 5'h00;
    {addrLog, ackLog, stopCnt, nSent, shift} = 0;
    bitCnt = 0;
  end

  // -------------------------------------------------------------
  // START and STOP: data edges while the clock is high
  // -------------------------------------------------------------
  always @(negedge sda)
  begin
    if (scl === 1'b1)
    begin
      // a repeated START restarts the header search
      {active, firstByte} = 2'h3;
      {reading, sending, sdaLow} = 3'h0;
      bitCnt = 0;
      nSent = 8'h00;
    end
  end

  always @(posedge sda)
  begin
    if (scl === 1'b1)
    begin
      active = 1'b0;
      stopCnt = stopCnt + 8'h01;
    end
  end

  // sample on the rising clock: address bits or the master's answer
  always @(posedge scl)
  begin
    if (active)
    begin
      if (bitCnt < 8 && !reading)
        shift = {shift[6:0], sda};
      if (bitCnt == 8 && sending)
        ackLog = {ackLog[6:0], sda};
      bitCnt++;
    end
  end

  // change sda only while the clock is low, so no false START/STOP
  always @(negedge scl)
  begin
    if (active)
    begin
      sdaLow = 1'b0;
      if (bitCnt == 8 && !reading)
      begin
        addrLog = {addrLog[23:0], shift};
        sdaLow = !refuse;
        // only the first byte after a START may be a read header
        reading = firstByte && shift[0] && !refuse;
        firstByte = 1'b0;
      end
      else if (bitCnt == 9)
      begin
        bitCnt = 0;
        if (sending && ackLog[0])
          {reading, sending, active} = 3'h0;
        else if (reading)
        begin
          if (sending)
            nSent = nSent + 8'h01;
          sending = 1'b1;
        end
      end
      cur = txBase + nSent;
      if (sending && bitCnt < 8)
        sdaLow = ~cur[7 - bitCnt];
    end
  end
endmodule

/* tb_top.sv */
// Purpose: self-checking bench of the two-wire master read sequencer
// Assumes: shortened bus timing through QUARTER; pull-ups on both lines
// Notes: software ports driven on the falling edge of sys_clk
`timescale 1ns/10ps

module tb_top
  import imrs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset_n, clkEn, interfaceEnable, modeMaster, txIntEnable;
  logic notAckRequest, startSet, stopSet, dataWrite, dataRead;
  logic [DATA_W-1:0] dataWrData, dataRdData;
  logic startPending, stopPending, txDataEmpty, rxDataFull;
  logic notAckIntFlag, ackValidFlag, ackFlag, tenBitHeader, busy;
  logic txInterrupt, rxInterrupt, sdaOe, sclOe, sdaLow, refuse;
  logic [7:0] txBase, ackLog, stopCnt, s;
  logic [31:0] addrLog;
  wire sda;
  wire scl;
  int err_count = 0;
  int compares = 0;

  // -------------------------------------------------------------
  // clocks and the wired-and bus
  // -------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;
  // link clock starts off phase so the crossings are exercised
  initial #3 forever #7.5 linkClk = ~linkClk;
  assign sda = ~(sdaOe | sdaLow);
  assign scl = ~sclOe;

  imrs_top #(.QUARTER(2)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clkEn(clkEn), .linkClk(linkClk), .interfaceEnable(interfaceEnable),
    .modeMaster(modeMaster), .txIntEnable(txIntEnable),
    .notAckRequest(notAckRequest), .startSet(startSet), .stopSet(stopSet),
    .dataWrite(dataWrite), .dataWrData(dataWrData), .dataRead(dataRead),
    .dataRdData(dataRdData), .startPending(startPending),
    .stopPending(stopPending), .txDataEmpty(txDataEmpty),
    .rxDataFull(rxDataFull), .notAckIntFlag(notAckIntFlag),
    .ackValidFlag(ackValidFlag), .ackFlag(ackFlag),
    .tenBitHeader(tenBitHeader), .busy(busy), .txInterrupt(txInterrupt),
    .rxInterrupt(rxInterrupt), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
    .sclIn(scl), .sclOut(), .sclOe(sclOe));

  imrs_slave_model slave (.scl(scl), .sda(sda), .sdaLow(sdaLow),
    .refuse(refuse), .txBase(txBase), .addrLog(addrLog), .ackLog(ackLog),
    .stopCnt(stopCnt));

  // -------------------------------------------------------------
  // compare, access and wait tasks
  // -------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one software access: 0 write data, 1 start, 2 stop, 3 read data
  task automatic put(input int sel, input logic [7:0] d);
    @(negedge sys_clk);
    case (sel)
      0: {dataWrite, dataWrData} = {1'b1, d};
      1: startSet = 1'b1;
      2: stopSet = 1'b1;
      default: dataRead = 1'b1;
    endcase
    @(negedge sys_clk);
    {dataWrite, startSet, stopSet, dataRead} = 4'h0;
  endtask

  function automatic logic seen(input int sel);
    case (sel)
      0: return rxDataFull === 1'b1;
      1: return txInterrupt === 1'b1;
      2: return busy === 1'b0;
      default: return notAckIntFlag === 1'b1;
    endcase
  endfunction

  // bounded wait; a hang is reported and closes the run
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (!seen(sel) && n < 5000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 5000)
    begin
      err_count++;
      $display("[FAIL] t=%0t wait=%h exp=%h", $time, sel, 1);
      finish_test();
    end
  endtask

  // read n bytes, asking not-acknowledge on the last when n is 2 or more, then stop
  task automatic read_rest(input int n);
    for (int i = 0; i < n; i++)
    begin
      wait_for(0);
      chk_byte(dataRdData, txBase + 8'(i));
      chk_flag(rxInterrupt, 1'b1);
      if (i == n - 2)
        notAckRequest = 1'b1;
      put(3, 8'h00);
    end
    chk_flag(notAckIntFlag, 1'b1);
    chk_byte(ackLog & ((8'h01 << n) - 8'h01), 8'h01);
    s = stopCnt;
    put(2, 8'h00);
    wait_for(2);
    chk_flag(stopPending, 1'b0);
    chk_flag(notAckIntFlag, 1'b0);
    chk_byte(stopCnt, s + 8'h01);
  endtask

  task automatic finish_test();
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    {reset_n, interfaceEnable, modeMaster, txIntEnable} = 4'h0;
    {startSet, stopSet, dataWrite, dataRead, refuse} = 5'h00;
    {clkEn, notAckRequest} = 2'h3;
    dataWrData = 8'h00;
    txBase = 8'ha5;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk_flag(txDataEmpty, 1'b1);
    // a frozen clock enable must ignore a data write
    clkEn = 1'b0;
    put(0, 8'ha7);
    chk_flag(txDataEmpty, 1'b1);
    clkEn = 1'b1;
    // single-byte 7-bit read, start held off until master mode is on
    interfaceEnable = 1'b1;
    put(0, 8'ha7);
    chk_flag(txDataEmpty, 1'b0);
    put(1, 8'h00);
    repeat (40) @(negedge sys_clk);
    chk_flag(startPending, 1'b1);
    chk_flag(sclOe, 1'b0);
    modeMaster = 1'b1;
    wait_for(0);
    chk_flag(ackFlag, 1'b1);
    chk_flag(ackValidFlag, 1'b1);
    chk_byte(addrLog[7:0], 8'ha7);
    chk_flag(tenBitHeader, 1'b0);
    read_rest(1);
    // three-byte 7-bit read: acknowledge, acknowledge, refuse
    notAckRequest = 1'b0;
    put(0, 8'h4d);
    put(1, 8'h00);
    read_rest(3);
    // address refused by the slave, then stop flushes queued data
    refuse = 1'b1;
    put(0, 8'h33);
    put(1, 8'h00);
    wait_for(3);
    chk_flag(ackValidFlag, 1'b1);
    chk_flag(ackFlag, 1'b0);
    txIntEnable = 1'b0;
    put(0, 8'h3c);
    s = stopCnt;
    put(2, 8'h00);
    wait_for(2);
    chk_flag(notAckIntFlag, 1'b0);
    chk_flag(stopPending, 1'b0);
    chk_flag(txDataEmpty, 1'b1);
    chk_byte(stopCnt, s + 8'h01);
    // two-byte 10-bit read with repeated START, no width setting
    refuse = 1'b0;
    // request bit is left set by the last read; two bytes are wanted here
    notAckRequest = 1'b0;
    txIntEnable = 1'b1;
    put(0, 8'hf4);
    put(1, 8'h00);
    wait_for(1);
    chk_byte(addrLog[7:0], 8'h33);
    put(0, 8'h5a);
    wait_for(1);
    chk_byte(addrLog[7:0], 8'hf4);
    put(1, 8'h00);
    put(0, 8'hf5);
    read_rest(2);
    chk_byte(addrLog[15:8], 8'h5a);
    chk_byte(addrLog[7:0], 8'hf5);
    chk_flag(tenBitHeader, 1'b1);
    // single-byte 10-bit read: not-acknowledge set with the read header
    put(0, 8'hf4);
    put(1, 8'h00);
    wait_for(1);
    put(0, 8'h5a);
    wait_for(1);
    put(1, 8'h00);
    notAckRequest = 1'b1;
    put(0, 8'hf5);
    read_rest(1);
    chk_byte(addrLog[15:8], 8'h5a);
    chk_byte(addrLog[7:0], 8'hf5);
    finish_test();
  end
endmodule
